// ---- verilog/uef_ctrl.sv ----
// Enhanced feature control: baud generators, buffer and control logic.

`include "uef_params.svh"

module uef_buf2 #(
	parameter int W = 9
) (
	// Clock and reset.
	input  wire logic         clock,
	input  wire logic         rstn,
	// Filling side.
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side.
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic         vld1_q;
	logic [W-1:0] e1_q;
	logic         push;
	logic         pop;

	assign push     = in_valid & ~vld1_q;
	assign pop      = out_valid & out_ready;

	// Ready is kept as its own flop, the inverse of the second entry's flag.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			out_valid <= 1'b0;
			vld1_q    <= 1'b0;
			in_ready  <= 1'b1;
			out_data  <= '0;
			e1_q      <= '0;
		end else if (pop) begin
			// Head leaves; the second entry moves up or the new word enters.
			out_valid <= vld1_q | push;
			vld1_q    <= 1'b0;
			in_ready  <= 1'b1;
			out_data  <= vld1_q ? e1_q : in_data;
			if (vld1_q && push) begin
				vld1_q   <= 1'b1;
				in_ready <= 1'b0;
				e1_q     <= in_data;
			end
		end else if (push) begin
			if (out_valid) begin
				vld1_q   <= 1'b1;
				in_ready <= 1'b0;
				e1_q     <= in_data;
			end else begin
				out_valid <= 1'b1;
				out_data  <= in_data;
			end
		end
	end
endmodule

module uef_brg
	import uef_pkg::*;
(
	// Clock and reset.
	input  wire logic         clock,
	input  wire logic         rstn,
	// Divisor setting.
	input  uef_brg_cfg_t      cfg,
	// Ticks.
	output logic              sample_tick,
	output logic              bit_tick
);
	logic [15:0] cnt_q;
	logic [3:0]  acc_q;
	logic        extra_q;
	logic [3:0]  os_q;
	logic [16:0] last;
	logic [4:0]  acc_sum;
	logic [3:0]  os_last;
	logic        period_end;

	// A divisor of zero stops the generator instead of dividing by 65536.
	assign last       = 17'(cfg.div) - 17'h1 + 17'(extra_q);
	assign acc_sum    = {1'b0, acc_q} + {1'b0, cfg.frac};
	assign period_end = (cfg.div != 16'h0) && ({1'b0, cnt_q} == last);

	always_comb begin
		unique case (cfg.samp)
			2'b00:   os_last = `UEF_OS16_LAST;
			2'b01:   os_last = `UEF_OS8_LAST;
			default: os_last = `UEF_OS4_LAST;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_q   <= 16'h0;
			acc_q   <= 4'h0;
			extra_q <= 1'b0;
		end else if (cfg.div == 16'h0) begin
			cnt_q   <= 16'h0;
			extra_q <= 1'b0;
		end else if (period_end) begin
			// Fraction spreads frac extra cycles over sixteen periods.
			cnt_q   <= 16'h0;
			acc_q   <= acc_sum[3:0];
			extra_q <= acc_sum[4];
		end else begin
			cnt_q <= cnt_q + 16'h1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			os_q        <= 4'h0;
			sample_tick <= 1'b0;
			bit_tick    <= 1'b0;
		end else begin
			sample_tick <= period_end;
			bit_tick    <= period_end && (os_q >= os_last);
			if (period_end) begin
				os_q <= (os_q >= os_last) ? 4'h0 : os_q + 4'h1;
			end
		end
	end
endmodule

module uef_ctrl
	import uef_pkg::*;
(
	// Clock and reset.
	input  wire logic         clock,
	input  wire logic         rstn,
	// Register port from the serial bus front end.
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	input  wire logic [3:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	output logic [7:0]        reg_rdata,
	output logic              thr_ready,
	// UART core status.
	input  wire logic         fifo_enable,
	input  wire logic [7:0]   rx_count,
	input  wire logic [7:0]   tx_count,
	input  wire logic         thr_empty,
	input  wire logic         tsr_empty,
	input  wire logic         tx_busy,
	input  wire logic         rx_busy,
	input  wire logic         tx_fifo_push,
	input  wire logic         tx_bypass_done,
	input  wire logic         err_in_fifo,
	input  wire logic         err_at_rhr,
	input  uef_flow_ev_t      flow_ev,
	input  wire logic         rx_char,
	input  wire logic         core_sleep_req,
	input  wire logic         tx_serial,
	input  wire logic         rts_n_core,
	input  wire logic         dtr_n_core,
	// Transmit words to the core.
	output uef_tx_word_t      tx_word,
	output logic              tx_word_valid,
	input  wire logic         tx_word_ready,
	// Rate and trigger settings to the core.
	output logic              tx_sample_tick,
	output logic              tx_bit_tick,
	output logic              rx_sample_tick,
	output logic              rx_bit_tick,
	output logic [7:0]        rx_trig_level,
	output logic [7:0]        tx_trig_level,
	output logic [1:0]        trig_table,
	// Interrupt sources to the core.
	output logic              lsr_int,
	output logic              tx_int,
	output uef_flow_ev_t      flow_int,
	output logic              sleep_mode,
	// Pins.
	input  wire logic         sleep_pin_in,
	output logic              sleep_pin_out,
	output logic              sleep_pin_oe,
	input  wire logic         ir_rx_pin,
	output logic              ir_rx_data,
	output logic              tx_pin_out,
	output logic              tx_pin_oe,
	output logic              rts_n_out,
	output logic              rts_n_oe,
	output logic              dtr_n_out,
	output logic              dtr_n_oe
);
	logic [7:0]     lcr_q;
	logic [7:0]     efr_q;
	logic [7:0]     feature_control_q;
	logic [7:0]     enhanced_mode_select_q;
	logic [7:0]     spr_q;
	logic [1:0]     dld_sel_q;
	uef_brg_cfg_t   tx_cfg_q;
	uef_brg_cfg_t   rx_cfg_q;
	uef_brg_cfg_t   rx_use_cfg;
	uef_brg_cfg_t   rd_cfg;
	logic           alt_q;
	logic           bypass_used_q;
	uef_dir_state_t dir_q;
	logic           slp_s1_q;
	logic           slp_s2_q;
	logic           ir_s1_q;
	logic           ir_s2_q;
	logic           dlab;
	logic           wr_thr;
	logic           wr_dll;
	logic           wr_dlm;
	logic           wr_dld;
	logic           wr_spr;
	logic           wr_enhanced_mode_select;
	logic           rd_spr;
	logic           isr_read;
	logic [1:0]     brg_sel;
	logic           tgt_tx;
	logic           tgt_rx;
	logic [7:0]     fc_val;
	logic [7:0]     swap_val;
	logic [7:0]     rd_mux;
	logic           send_now;
	logic           sleep_req;
	logic           tx_start;
	logic           dir_level;
	uef_tx_word_t   buf_in;

	assign dlab     = lcr_q[`UEF_LCR_DLAB];
	assign wr_thr   = reg_wr && reg_addr == `UEF_ADDR_THR_DLL && !dlab;
	assign wr_dll   = reg_wr && reg_addr == `UEF_ADDR_THR_DLL && dlab;
	assign wr_dlm   = reg_wr && reg_addr == `UEF_ADDR_DLM && dlab;
	assign wr_dld   = reg_wr && reg_addr == `UEF_ADDR_DLD && dlab
		&& efr_q[`UEF_EFR_ENH];
	assign wr_spr   = reg_wr && reg_addr == `UEF_ADDR_SPR;
	assign wr_enhanced_mode_select  = wr_spr && feature_control_q[`UEF_FEATURE_CONTROL_SWAP];
	assign rd_spr   = reg_rd && reg_addr == `UEF_ADDR_SPR;
	assign isr_read = reg_rd && reg_addr == `UEF_ADDR_ISR;

	// A fraction write carries its own select bits and steers itself.
	assign brg_sel = wr_dld ? reg_wdata[7:6] : dld_sel_q;
	assign tgt_tx  = brg_sel == 2'b00 || brg_sel == 2'b01;
	assign tgt_rx  = brg_sel == 2'b00 || brg_sel == 2'b11;
	assign rd_cfg  = (dld_sel_q == 2'b10) ? rx_cfg_q : tx_cfg_q;
	assign rx_use_cfg = dld_sel_q[0] ? rx_cfg_q : tx_cfg_q;

	// Bypass tags only one byte per arming of the send-now bit.
	assign send_now = enhanced_mode_select_q[`UEF_ENHANCED_MODE_SELECT_SEND_NOW] && fifo_enable
		&& !bypass_used_q;
	assign buf_in   = '{bypass: send_now, data: reg_wdata};
	assign tx_start = tx_fifo_push
		|| (tx_word_valid && tx_word_ready && tx_word.bypass);

	always_comb begin
		fc_val = feature_control_q[`UEF_FEATURE_CONTROL_TRG_SEL] ? tx_count : rx_count;
		if (!enhanced_mode_select_q[0]) begin
			swap_val = rx_count;
		end else if (!enhanced_mode_select_q[1]) begin
			swap_val = tx_count;
		end else begin
			swap_val = alt_q ? tx_count : rx_count;
		end
	end

	always_comb begin
		unique case (reg_addr)
			`UEF_ADDR_THR_DLL: rd_mux = dlab ? rd_cfg.div[7:0] : 8'h00;
			`UEF_ADDR_DLM:     rd_mux = dlab ? rd_cfg.div[15:8] : 8'h00;
			`UEF_ADDR_DLD:     rd_mux = dlab ?
				{dld_sel_q, rd_cfg.samp, rd_cfg.frac} : 8'h00;
			`UEF_ADDR_LCR:     rd_mux = lcr_q;
			`UEF_ADDR_EFR:     rd_mux = efr_q;
			`UEF_ADDR_FEATURE_CONTROL:    rd_mux = feature_control_q;
			`UEF_ADDR_SPR: begin
				if (feature_control_q[`UEF_FEATURE_CONTROL_SWAP]) begin
					rd_mux = swap_val;
				end else if (lcr_q == `UEF_LCR_ENH_VIEW) begin
					rd_mux = fc_val;
				end else begin
					rd_mux = spr_q;
				end
			end
			`UEF_ADDR_ISR: rd_mux = {3'h0, tx_int, lsr_int, flow_int};
			default:       rd_mux = 8'h00;
		endcase
	end

	// Host-visible control registers.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lcr_q  <= `UEF_REG_RST;
			efr_q  <= `UEF_REG_RST;
			feature_control_q <= `UEF_REG_RST;
			spr_q  <= `UEF_SPR_RST;
		end else if (reg_wr) begin
			if (reg_addr == `UEF_ADDR_LCR) begin
				lcr_q <= reg_wdata;
			end
			if (reg_addr == `UEF_ADDR_EFR) begin
				efr_q <= reg_wdata;
			end
			if (reg_addr == `UEF_ADDR_FEATURE_CONTROL) begin
				feature_control_q <= reg_wdata & `UEF_FEATURE_CONTROL_WMASK;
			end
			if (wr_spr && !feature_control_q[`UEF_FEATURE_CONTROL_SWAP]) begin
				spr_q <= reg_wdata;
			end
		end
	end

	// Mode register; a new arming beats a completion in the same cycle.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			enhanced_mode_select_q        <= `UEF_REG_RST;
			bypass_used_q <= 1'b0;
		end else if (wr_enhanced_mode_select) begin
			enhanced_mode_select_q        <= reg_wdata & `UEF_ENHANCED_MODE_SELECT_WMASK;
			bypass_used_q <= 1'b0;
		end else begin
			if (tx_bypass_done) begin
				enhanced_mode_select_q[`UEF_ENHANCED_MODE_SELECT_SEND_NOW] <= 1'b0;
			end
			if (wr_thr && thr_ready && send_now) begin
				bypass_used_q <= 1'b1;
			end
		end
	end

	// Alternating counter restarts at receive after each mode write.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			alt_q <= 1'b0;
		end else if (wr_enhanced_mode_select) begin
			alt_q <= 1'b0;
		end else if (rd_spr && feature_control_q[`UEF_FEATURE_CONTROL_SWAP] && enhanced_mode_select_q[1:0] == 2'b11) begin
			alt_q <= ~alt_q;
		end
	end

	// Baud rate settings.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_cfg_q  <= '0;
			rx_cfg_q  <= '0;
			dld_sel_q <= 2'b00;
		end else begin
			if (wr_dld) begin
				dld_sel_q <= reg_wdata[7:6];
			end
			if (tgt_tx) begin
				if (wr_dll) tx_cfg_q.div[7:0] <= reg_wdata;
				if (wr_dlm) tx_cfg_q.div[15:8] <= reg_wdata;
				if (wr_dld) {tx_cfg_q.samp, tx_cfg_q.frac} <= reg_wdata[5:0];
			end
			if (tgt_rx) begin
				if (wr_dll) rx_cfg_q.div[7:0] <= reg_wdata;
				if (wr_dlm) rx_cfg_q.div[15:8] <= reg_wdata;
				if (wr_dld) {rx_cfg_q.samp, rx_cfg_q.frac} <= reg_wdata[5:0];
			end
		end
	end

	uef_brg u_tx_brg (
		.clock       (clock),
		.rstn        (rstn),
		.cfg         (tx_cfg_q),
		.sample_tick (tx_sample_tick),
		.bit_tick    (tx_bit_tick)
	);

	uef_brg u_rx_brg (
		.clock       (clock),
		.rstn        (rstn),
		.cfg         (rx_use_cfg),
		.sample_tick (rx_sample_tick),
		.bit_tick    (rx_bit_tick)
	);

	// Holding buffer; a full buffer drops thr_ready and refuses writes.
	uef_buf2 #(
		.W ($bits(uef_tx_word_t))
	) u_buf (
		.clock     (clock),
		.rstn      (rstn),
		.in_valid  (wr_thr),
		.in_ready  (thr_ready),
		.in_data   (buf_in),
		.out_valid (tx_word_valid),
		.out_ready (tx_word_ready),
		.out_data  (tx_word)
	);

	// Trigger levels and table.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx_trig_level <= `UEF_REG_RST;
			tx_trig_level <= `UEF_REG_RST;
			trig_table    <= 2'b00;
		end else begin
			trig_table <= feature_control_q[`UEF_FEATURE_CONTROL_TBL_LO +: 2];
			if (reg_wr && reg_addr == `UEF_ADDR_TRG) begin
				if (feature_control_q[`UEF_FEATURE_CONTROL_TRG_SEL]) begin
					tx_trig_level <= reg_wdata;
				end else begin
					rx_trig_level <= reg_wdata;
				end
			end
		end
	end

	// Interrupt sources; a new event wins over a clear in the same cycle.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			flow_int <= '0;
			lsr_int  <= 1'b0;
			tx_int   <= 1'b0;
		end else begin
			lsr_int <= enhanced_mode_select_q[`UEF_ENHANCED_MODE_SELECT_LSR_IMM] ? err_in_fifo : err_at_rhr;
			tx_int  <= feature_control_q[`UEF_FEATURE_CONTROL_AUTO485] ? tsr_empty : thr_empty;
			flow_int.xon  <= flow_ev.xon | (flow_int.xon & ~isr_read);
			flow_int.xoff <= flow_ev.xoff | (flow_int.xoff & ~isr_read
				& ~(flow_ev.xon & ~enhanced_mode_select_q[`UEF_ENHANCED_MODE_SELECT_CLR_MODE]));
			flow_int.special <= flow_ev.special | (flow_int.special
				& ~isr_read
				& ~(rx_char & ~enhanced_mode_select_q[`UEF_ENHANCED_MODE_SELECT_CLR_MODE]));
		end
	end

	// Direction control: RTS returns to receive level once the line drains, while the state waits one bit tick in HOLD.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dir_q <= UEF_DIR_RX;
		end else begin
			unique case (dir_q)
				UEF_DIR_RX: if (tx_start) dir_q <= UEF_DIR_TX;
				UEF_DIR_TX: begin
					if (tsr_empty && thr_empty && !tx_busy && !tx_start) begin
						dir_q <= UEF_DIR_HOLD;
					end
				end
				UEF_DIR_HOLD: begin
					if (tx_start) begin
						dir_q <= UEF_DIR_TX;
					end else if (tx_bit_tick) begin
						dir_q <= UEF_DIR_RX;
					end
				end
				default: dir_q <= UEF_DIR_RX;
			endcase
		end
	end

	assign dir_level = (dir_q != UEF_DIR_TX) ^ enhanced_mode_select_q[`UEF_ENHANCED_MODE_SELECT_INV_RTS];

	// Modem outputs.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_pin_out <= 1'b1;
			rts_n_out  <= 1'b1;
			dtr_n_out  <= 1'b1;
			tx_pin_oe  <= 1'b1;
			rts_n_oe   <= 1'b1;
			dtr_n_oe   <= 1'b1;
		end else begin
			tx_pin_out <= tx_serial;
			rts_n_out  <= feature_control_q[`UEF_FEATURE_CONTROL_AUTO485] ? dir_level : rts_n_core;
			dtr_n_out  <= dtr_n_core;
			tx_pin_oe  <= ~enhanced_mode_select_q[`UEF_ENHANCED_MODE_SELECT_TRISTATE];
			rts_n_oe   <= ~enhanced_mode_select_q[`UEF_ENHANCED_MODE_SELECT_TRISTATE];
			dtr_n_oe   <= ~enhanced_mode_select_q[`UEF_ENHANCED_MODE_SELECT_TRISTATE];
		end
	end

	// Pin synchronisers.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			slp_s1_q <= 1'b0;
			slp_s2_q <= 1'b0;
			ir_s1_q  <= 1'b0;
			ir_s2_q  <= 1'b0;
		end else begin
			slp_s1_q <= sleep_pin_in;
			slp_s2_q <= slp_s1_q;
			ir_s1_q  <= ir_rx_pin;
			ir_s2_q  <= ir_s1_q;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ir_rx_data <= 1'b0;
		end else begin
			ir_rx_data <= ir_s2_q ^ feature_control_q[`UEF_FEATURE_CONTROL_IR_INV];
		end
	end

	// Sleep waits for both shifters to finish their current byte.
	assign sleep_req = core_sleep_req
		|| (!feature_control_q[`UEF_FEATURE_CONTROL_SLP_FN] && slp_s2_q);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sleep_mode    <= 1'b0;
			sleep_pin_out <= 1'b1;
			sleep_pin_oe  <= 1'b0;
		end else begin
			if (!sleep_req) begin
				sleep_mode <= 1'b0;
			end else if (!tx_busy && !rx_busy) begin
				sleep_mode <= 1'b1;
			end
			sleep_pin_out <= ~sleep_mode;
			sleep_pin_oe  <= feature_control_q[`UEF_FEATURE_CONTROL_SLP_FN];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end
	end
endmodule

// ---- verilog/uef_params.svh ----
// Register offsets, field positions, reset values and counts of the block.
`ifndef UEF_PARAMS_SVH
`define UEF_PARAMS_SVH

`define UEF_ADDR_THR_DLL  4'h0
`define UEF_ADDR_DLM      4'h1
`define UEF_ADDR_DLD      4'h2
`define UEF_ADDR_LCR      4'h3
`define UEF_ADDR_EFR      4'h4
`define UEF_ADDR_FEATURE_CONTROL     4'h5
`define UEF_ADDR_TRG      4'h6
`define UEF_ADDR_SPR      4'h7
`define UEF_ADDR_ISR      4'h8

`define UEF_LCR_ENH_VIEW  8'hbf
`define UEF_LCR_DLAB      7
`define UEF_EFR_ENH       4

`define UEF_REG_RST       8'h00
`define UEF_SPR_RST       8'hff

`define UEF_ENHANCED_MODE_SELECT_SEND_NOW 2
`define UEF_ENHANCED_MODE_SELECT_INV_RTS  3
`define UEF_ENHANCED_MODE_SELECT_TRISTATE 4
`define UEF_ENHANCED_MODE_SELECT_LSR_IMM  6
`define UEF_ENHANCED_MODE_SELECT_CLR_MODE 7
`define UEF_ENHANCED_MODE_SELECT_WMASK    8'hdf

`define UEF_DLD_SEL_LO    6

`define UEF_FEATURE_CONTROL_SLP_FN   0
`define UEF_FEATURE_CONTROL_IR_INV   2
`define UEF_FEATURE_CONTROL_AUTO485  3
`define UEF_FEATURE_CONTROL_TBL_LO   4
`define UEF_FEATURE_CONTROL_SWAP     6
`define UEF_FEATURE_CONTROL_TRG_SEL  7
`define UEF_FEATURE_CONTROL_WMASK    8'hfd

`define UEF_OS16_LAST     4'hf
`define UEF_OS8_LAST      4'h7
`define UEF_OS4_LAST      4'h3

`endif

// ---- verilog/uef_pkg.sv ----
// Types shared by the enhanced feature control block.
package uef_pkg;

	typedef struct packed {
		logic [15:0] div;
		logic [1:0]  samp;
		logic [3:0]  frac;
	} uef_brg_cfg_t;

	typedef struct packed {
		logic       bypass;
		logic [7:0] data;
	} uef_tx_word_t;

	typedef struct packed {
		logic xoff;
		logic xon;
		logic special;
	} uef_flow_ev_t;

	typedef enum logic [2:0] {
		UEF_DIR_RX   = 3'h1,
		UEF_DIR_TX   = 3'h2,
		UEF_DIR_HOLD = 3'h4
	} uef_dir_state_t;

endpackage

// ---- verif/uef_core_model.sv ----
// Behavioural model of the UART core side that takes transmit words.
module uef_core_model
	import uef_pkg::*;
(
	// Clock and reset.
	input  wire logic    clock,
	input  wire logic    rstn,
	// Transmit words from the block.
	input  uef_tx_word_t tx_word,
	input  wire logic    tx_word_valid,
	output logic         tx_word_ready,
	output logic         tx_bypass_done,
	// Bench control: hold off acceptance.
	input  wire logic    stall
);
	timeunit 1ns;
	timeprecision 1ns;

	uef_tx_word_t	q[$];

	// Ready is registered, so a stall takes effect one cycle late, as a core would.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_word_ready <= 1'b0;
			tx_bypass_done <= 1'b0;
		end else begin
			tx_bypass_done <= 1'b0;
			if (tx_word_valid && tx_word_ready) begin
				q.push_back(tx_word);
				tx_bypass_done <= tx_word.bypass;
			end
			tx_word_ready <= !stall;
		end
	end
endmodule

// ---- verif/uef_ctrl_props.sv ----
// Concurrent checks on the ports of the enhanced feature control block.
module uef_ctrl_props
	import uef_pkg::*;
(
	input wire logic       clock,
	input wire logic       rstn,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       tx_busy,
	input wire logic       rx_busy,
	input uef_flow_ev_t    flow_ev,
	input uef_flow_ev_t    flow_int,
	input uef_tx_word_t    tx_word,
	input wire logic       tx_word_valid,
	input wire logic       tx_word_ready,
	input wire logic [1:0] trig_table,
	input wire logic       lsr_int,
	input wire logic       sleep_mode,
	input wire logic       sleep_pin_out,
	input wire logic       sleep_pin_oe,
	input wire logic       tx_pin_oe,
	input wire logic       rts_n_oe,
	input wire logic       dtr_n_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	tri_same_a: assert property (tx_pin_oe == rts_n_oe && rts_n_oe == dtr_n_oe)
		else $error("modem output enables disagree");
	power_pin_a: assert property (sleep_pin_oe |->
		sleep_pin_out == !$past(sleep_mode))
		else $error("power down pin does not follow sleep");
	sleep_idle_a: assert property ($rose(sleep_mode) |->
		!$past(tx_busy) && !$past(rx_busy))
		else $error("sleep entered while busy");
	word_hold_a: assert property (tx_word_valid && !tx_word_ready |=>
		tx_word_valid && $stable(tx_word))
		else $error("transmit word dropped during stall");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	xon_keep_a: assert property (flow_int.xon && !(reg_rd && reg_addr == 4'h8)
		|=> flow_int.xon)
		else $error("xon flag cleared without status read");
	xon_set_a: assert property (flow_ev.xon |=> flow_int.xon)
		else $error("xon flag not set");
	table_sel_a: assert property (reg_wr && reg_addr == 4'h5 |=> ##1
		trig_table == $past(reg_wdata[5:4], 2))
		else $error("trigger table not taken");
	trg_wo_a: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata == 8'h00)
		else $error("write only trigger register read back");

	c_bypass: cover property (tx_word_valid && tx_word_ready && tx_word.bypass);
	c_sleep: cover property ($rose(sleep_mode));
	c_xoff: cover property (flow_int.xoff);
	c_lsr: cover property ($rose(lsr_int));
endmodule

bind uef_ctrl uef_ctrl_props u_props (.clock, .rstn, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .tx_busy, .rx_busy, .flow_ev,
	.flow_int, .tx_word, .tx_word_valid, .tx_word_ready, .trig_table,
	.lsr_int, .sleep_mode, .sleep_pin_out, .sleep_pin_oe, .tx_pin_oe,
	.rts_n_oe, .dtr_n_oe);

// ---- verif/uef_ctrl_bench.sv ----
// Self-checking bench for the enhanced feature control block.
module uef_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import uef_pkg::*;

	logic	clock, rstn, reg_wr, reg_rd, fifo_enable, thr_empty, tsr_empty;
	logic	tx_busy, rx_busy, tx_fifo_push, err_in_fifo, err_at_rhr, rx_char;
	logic	core_sleep_req, stall, tx_word_ready, tx_bypass_done, thr_ready;
	logic	tx_word_valid, tx_st, tx_bt, rx_st, lsr_int, tx_int, sleep_mode;
	logic	sp_out, sp_oe, tx_oe, rts_n_out, rts_oe, dtr_oe;
	logic	ir_pin, slp_pin, tx_ser, rts_n_in, dtr_n_in, ir_data, tx_out;
	logic	dtr_n_o, rx_bt;
	logic	[7:0] rx_tl, tx_tl;
	logic	[3:0] reg_addr;
	logic	[7:0] reg_wdata, reg_rdata, rx_count, tx_count;
	logic	[1:0] trig_table;
	uef_flow_ev_t	flow_ev, flow_int;
	uef_tx_word_t	tx_word;
	int	failures, n_compared, cyc;

	uef_ctrl i_dut (.clock, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .thr_ready, .fifo_enable, .rx_count, .tx_count,
		.thr_empty, .tsr_empty, .tx_busy, .rx_busy, .tx_fifo_push,
		.tx_bypass_done, .err_in_fifo, .err_at_rhr, .flow_ev, .rx_char,
		.core_sleep_req, .tx_serial(tx_ser), .rts_n_core(rts_n_in),
		.dtr_n_core(dtr_n_in), .tx_word, .tx_word_valid, .tx_word_ready,
		.tx_sample_tick(tx_st), .tx_bit_tick(tx_bt), .rx_sample_tick(rx_st),
		.rx_bit_tick(rx_bt), .rx_trig_level(rx_tl), .tx_trig_level(tx_tl),
		.trig_table, .lsr_int, .tx_int, .flow_int, .sleep_mode,
		.sleep_pin_in(slp_pin), .sleep_pin_out(sp_out), .sleep_pin_oe(sp_oe),
		.ir_rx_pin(ir_pin), .ir_rx_data(ir_data), .tx_pin_out(tx_out),
		.tx_pin_oe(tx_oe), .rts_n_out, .rts_n_oe(rts_oe),
		.dtr_n_out(dtr_n_o), .dtr_n_oe(dtr_oe));

	uef_core_model i_core (.clock, .rstn, .tx_word, .tx_word_valid,
		.tx_word_ready, .tx_bypass_done, .stall);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task conclude;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task cy(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task w(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// Read data lands one edge after the strobe, so it is sampled just past it.
	task rd(input logic [3:0] a);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
	endtask

	task r(input logic [3:0] a, input logic [7:0] e);
		rd(a);
		chk(reg_rdata, e);
	endtask

	task ev(input logic [3:0] e);
		@(posedge clock);
		{rx_char, flow_ev} <= e;
		@(posedge clock);
		{rx_char, flow_ev} <= 4'h0;
		#1;
	endtask

	function logic tk(input int s);
		return s == 0 ? tx_st : s == 1 ? rx_st : s == 2 ? tx_bt : rx_bt;
	endfunction

	// The first two intervals after a setting change may be partial, so only the third counts.
	task gap(input int s, input int e);
		int n;
		n = 0;
		while (!tk(s) && n < 300) begin
			cy(1);
			n++;
		end
		repeat (2) begin
			n = 0;
			do begin
				cy(1);
				n++;
			end while (!tk(s) && n < 300);
		end
		chk(n, e);
	endtask

	task t_scratch;
		r(4'h7, 8'hff);
		w(4'h7, 8'h5a);
		r(4'h7, 8'h5a);
		w(4'h5, 8'h40);
		w(4'h7, 8'h00);
		r(4'h7, 8'h11);
		w(4'h7, 8'h01);
		r(4'h7, 8'h22);
		w(4'h7, 8'h03);
		r(4'h7, 8'h11);
		r(4'h7, 8'h22);
		r(4'h7, 8'h11);
		w(4'h5, 8'h80);
		w(4'h3, 8'hbf);
		r(4'h7, 8'h22);
		w(4'h5, 8'h02);
		r(4'h5, 8'h00);
		r(4'h7, 8'h11);
		w(4'h3, 8'h00);
		r(4'h7, 8'h5a);
	endtask

	task t_bypass;
		w(4'h5, 8'h40);
		stall <= 1'b1;
		w(4'h7, 8'h04);
		w(4'h0, 8'ha5);
		w(4'h0, 8'h3c);
		cy(3);
		chk(thr_ready, 1'b0);
		w(4'h0, 8'h99);
		stall <= 1'b0;
		cy(10);
		chk(i_core.q.size(), 2);
		chk(i_core.q[0], 9'h1a5);
		chk(i_core.q[1], 9'h03c);
		w(4'h7, 8'h04);
		w(4'h0, 8'h77);
		cy(8);
		chk(i_core.q[2], 9'h177);
	endtask

	task t_flow;
		w(4'h7, 8'h00);
		ev(4'b0100);
		chk(flow_int, 3'b100);
		ev(4'b0010);
		chk(flow_int, 3'b010);
		ev(4'b0001);
		ev(4'b1000);
		chk(flow_int, 3'b010);
		rd(4'h8);
		cy(1);
		chk(flow_int, 3'b000);
		w(4'h7, 8'h80);
		ev(4'b0001);
		ev(4'b1000);
		ev(4'b0100);
		ev(4'b0010);
		chk(flow_int, 3'b111);
		rd(4'h8);
		cy(1);
		chk(flow_int, 3'b000);
		err_in_fifo <= 1'b1;
		cy(3);
		chk(lsr_int, 1'b0);
		err_at_rhr <= 1'b1;
		cy(3);
		chk(lsr_int, 1'b1);
		err_at_rhr <= 1'b0;
		w(4'h7, 8'hc0);
		cy(3);
		chk(lsr_int, 1'b1);
		err_in_fifo <= 1'b0;
	endtask

	task t_divisor;
		w(4'h3, 8'h80);
		w(4'h4, 8'h10);
		w(4'h2, 8'h00);
		w(4'h0, 8'h04);
		w(4'h1, 8'h00);
		gap(0, 4);
		gap(2, 64);
		w(4'h2, 8'h10);
		gap(2, 32);
		w(4'h2, 8'h20);
		gap(2, 16);
		w(4'h2, 8'h28);
		gap(2, 18);
		w(4'h2, 8'hc0);
		w(4'h0, 8'h08);
		gap(1, 8);
		gap(2, 18);
		w(4'h2, 8'h80);
		w(4'h0, 8'h02);
		gap(2, 18);
		gap(3, 18);
		w(4'h4, 8'h00);
		w(4'h2, 8'h00);
		gap(2, 18);
		w(4'h3, 8'h00);
	endtask

	task t_direction;
		w(4'h5, 8'h40);
		tsr_empty <= 1'b0;
		cy(3);
		chk(tx_int, 1'b1);
		w(4'h5, 8'h48);
		cy(2);
		chk({tx_int, rts_n_out}, 2'b01);
		tsr_empty <= 1'b1;
		cy(3);
		chk(tx_int, 1'b1);
		{tx_busy, tsr_empty, thr_empty, tx_fifo_push} <= 4'b1001;
		@(posedge clock);
		tx_fifo_push <= 1'b0;
		cy(3);
		chk(rts_n_out, 1'b0);
		{tx_busy, tsr_empty, thr_empty} <= 3'b011;
		cy(40);
		chk(rts_n_out, 1'b1);
		w(4'h7, 8'h08);
		cy(2);
		chk(rts_n_out, 1'b0);
		w(4'h7, 8'h10);
		cy(2);
		chk({tx_oe, rts_oe, dtr_oe}, 3'b000);
		w(4'h7, 8'h00);
		cy(2);
		chk({tx_oe, rts_oe, dtr_oe}, 3'b111);
	endtask

	task t_sleep;
		w(4'h5, 8'h01);
		{tx_busy, rx_busy, core_sleep_req} <= 3'b111;
		cy(4);
		chk({sp_oe, sleep_mode}, 2'b10);
		tx_busy <= 1'b0;
		cy(3);
		chk(sleep_mode, 1'b0);
		rx_busy <= 1'b0;
		cy(3);
		chk({sleep_mode, sp_out}, 2'b10);
		core_sleep_req <= 1'b0;
		cy(3);
		chk({sleep_mode, sp_out}, 2'b01);
	endtask

	task t_pins;
		w(4'h5, 8'h00);
		w(4'h6, 8'h33);
		w(4'h5, 8'hb4);
		w(4'h6, 8'h44);
		r(4'h6, 8'h00);
		cy(2);
		chk({rx_tl, tx_tl}, 16'h3344);
		chk(trig_table, 2'b11);
		chk(ir_data, 1'b1);
		ir_pin <= 1'b1;
		{tx_ser, rts_n_in, dtr_n_in} <= 3'b000;
		cy(4);
		chk(ir_data, 1'b0);
		chk({tx_out, rts_n_out, dtr_n_o}, 3'b000);
		w(4'h5, 8'h00);
		cy(2);
		chk(ir_data, 1'b1);
		slp_pin <= 1'b1;
		cy(4);
		chk({sleep_mode, sp_oe}, 2'b10);
		slp_pin <= 1'b0;
		cy(4);
		chk(sleep_mode, 1'b0);
	endtask

	initial begin
		{rstn, reg_wr, reg_rd, tx_busy, rx_busy, tx_fifo_push} = 6'h00;
		{err_in_fifo, err_at_rhr, rx_char, core_sleep_req, stall} = 5'h00;
		{fifo_enable, thr_empty, tsr_empty} = 3'b111;
		{ir_pin, slp_pin, tx_ser, rts_n_in, dtr_n_in} = 5'b00111;
		{reg_addr, reg_wdata, flow_ev} = 15'h0000;
		rx_count = 8'h11;
		tx_count = 8'h22;
		failures = 0;
		n_compared = 0;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		t_scratch();
		t_bypass();
		t_flow();
		t_divisor();
		t_direction();
		t_sleep();
		t_pins();
		conclude();
	end

	// The whole sequence needs about 900 cycles; a hang is cut at 20000.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
endmodule
